// *** hw/tmt_timer.sv ***
`timescale 1ns/1ps
`include "tmt_defines.svh"

module tmt_timer
  import tmt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic [7:0]      sfr_rdata,
  input  wire logic       ext_clk,
  input  wire logic       high_byte_clock_pick,
  input  wire logic       low_byte_clock_pick,
  input  wire logic [7:0] reload_high,
  input  wire logic [7:0] reload_low,
  input  wire logic       timer_irq_enable,
  output logic            irq_req,
  output logic            capture_mode,
  output logic [7:0]      count_high,
  output logic [7:0]      count_low
);

  // ----------------------------------------------------------------------
  // state and clock ticks
  // ----------------------------------------------------------------------
  tmt_state_type st_reg;
  tmt_state_type st_next;
  logic          ext_sync1_reg;
  logic          ext_sync2_reg;
  logic          sys_tick;
  logic          ext_tick;
  logic          sel_tick;
  logic          tick_high;
  logic          tick_low;
  logic          wr_ctrl;
  logic          hi_wrap;
  logic          lo_wrap;
  tmt_src_type   src_high;
  tmt_src_type   src_low;
  logic [7:0]    ctrl_view;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
    end else begin
      ext_sync1_reg <= ext_clk;
      ext_sync2_reg <= ext_sync1_reg;
    end
  end

  tmt_tick_gen u_tick (
    .clk          (clk),
    .rst_n        (rst_n),
    .ext_clk_sync (ext_sync2_reg),
    .sys_tick     (sys_tick),
    .ext_tick     (ext_tick)
  );

  // ----------------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------------
  always_comb begin
    src_high = st_reg.ext_clock_select ? TMT_CLK_EXT_DIV : TMT_CLK_SYS_DIV;
    src_low  = src_high;
    if (high_byte_clock_pick) begin
      src_high = TMT_CLK_SYSTEM;
    end
    if (low_byte_clock_pick) begin
      src_low = TMT_CLK_SYSTEM;
    end
  end

  function automatic logic pick_tick(input tmt_src_type src, input logic st, input logic et);
    case (src)
      TMT_CLK_SYS_DIV: pick_tick = st;
      TMT_CLK_EXT_DIV: pick_tick = et;
      default:         pick_tick = 1'b1;
    endcase
  endfunction : pick_tick

  // ----------------------------------------------------------------------
  // counting, flags and register writes
  // ----------------------------------------------------------------------
  assign wr_ctrl = sfr_wr && (sfr_addr == `TMT_CTRL_ADDR);

  always_comb begin
    st_next   = st_reg;
    sel_tick  = pick_tick(src_low, sys_tick, ext_tick);
    tick_high = 1'b0;
    tick_low  = 1'b0;
    hi_wrap   = 1'b0;
    lo_wrap   = 1'b0;
    if (st_reg.split_select) begin
      tick_high = st_reg.run_control && pick_tick(src_high, sys_tick, ext_tick);
      tick_low  = sel_tick;
    end else begin
      tick_low  = st_reg.run_control && sel_tick;
    end
    if (tick_low) begin
      if (st_reg.count_low_byte == 8'hff) begin
        lo_wrap = 1'b1;
        st_next.count_low_byte = st_reg.split_select ? reload_low : 8'h00;
        if (!st_reg.split_select) begin
          if (st_reg.count_high_byte == 8'hff) begin
            hi_wrap = 1'b1;
            st_next.count_high_byte = reload_high;
            st_next.count_low_byte  = reload_low;
          end else begin
            st_next.count_high_byte = st_reg.count_high_byte + 8'h01;
          end
        end
      end else begin
        st_next.count_low_byte = st_reg.count_low_byte + 8'h01;
      end
    end
    if (tick_high) begin
      if (st_reg.count_high_byte == 8'hff) begin
        hi_wrap = 1'b1;
        st_next.count_high_byte = reload_high;
      end else begin
        st_next.count_high_byte = st_reg.count_high_byte + 8'h01;
      end
    end
    if (wr_ctrl) begin
      st_next.high_overflow_flag      = sfr_wdata[`TMT_BIT_HIGH_OVF];
      st_next.low_overflow_flag       = sfr_wdata[`TMT_BIT_LOW_OVF];
      st_next.low_overflow_irq_enable = sfr_wdata[`TMT_BIT_LOW_IEN];
      st_next.capture_enable          = sfr_wdata[`TMT_BIT_CAP_EN];
      st_next.split_select            = sfr_wdata[`TMT_BIT_SPLIT];
      st_next.run_control             = sfr_wdata[`TMT_BIT_RUN];
      st_next.ext_clock_select        = sfr_wdata[`TMT_BIT_EXT_CLK];
    end
    // hardware set wins over a software clear
    if (hi_wrap) begin
      st_next.high_overflow_flag = 1'b1;
    end
    if (lo_wrap) begin
      st_next.low_overflow_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // read side and outputs
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_view = `TMT_CTRL_RESET;
    ctrl_view[`TMT_BIT_HIGH_OVF] = st_reg.high_overflow_flag;
    ctrl_view[`TMT_BIT_LOW_OVF]  = st_reg.low_overflow_flag;
    ctrl_view[`TMT_BIT_LOW_IEN]  = st_reg.low_overflow_irq_enable;
    ctrl_view[`TMT_BIT_CAP_EN]   = st_reg.capture_enable;
    ctrl_view[`TMT_BIT_SPLIT]    = st_reg.split_select;
    ctrl_view[`TMT_BIT_RUN]      = st_reg.run_control;
    ctrl_view[`TMT_BIT_UNUSED]   = 1'b0;
    ctrl_view[`TMT_BIT_EXT_CLK]  = st_reg.ext_clock_select;
  end

  assign sfr_rdata = (sfr_rd && sfr_addr == `TMT_CTRL_ADDR) ? ctrl_view : 8'h00;

  assign irq_req = timer_irq_enable &&
                   (st_reg.high_overflow_flag ||
                    (st_reg.low_overflow_flag && st_reg.low_overflow_irq_enable));

  assign capture_mode = st_reg.capture_enable;
  assign count_high   = st_reg.count_high_byte;
  assign count_low    = st_reg.count_low_byte;

endmodule : tmt_timer

// *** shared/tmt_defines.svh ***
`ifndef TMT_DEFINES_SVH
`define TMT_DEFINES_SVH

// ----------------------------------------------------------------------
// register address
// ----------------------------------------------------------------------
`define TMT_CTRL_ADDR     8'h91
`define TMT_CTRL_RESET    8'h00

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define TMT_BIT_HIGH_OVF  7
`define TMT_BIT_LOW_OVF   6
`define TMT_BIT_LOW_IEN   5
`define TMT_BIT_CAP_EN    4
`define TMT_BIT_SPLIT     3
`define TMT_BIT_RUN       2
`define TMT_BIT_UNUSED    1
`define TMT_BIT_EXT_CLK   0

// ----------------------------------------------------------------------
// clock divisors
// ----------------------------------------------------------------------
`define TMT_SYS_DIV       12
`define TMT_EXT_DIV       8

`endif

// *** shared/tmt_pkg.sv ***
package tmt_pkg;

  typedef enum logic [1:0] {
    TMT_CLK_SYS_DIV,
    TMT_CLK_EXT_DIV,
    TMT_CLK_SYSTEM
  } tmt_src_type;

  typedef struct packed {
    logic       high_overflow_flag;
    logic       low_overflow_flag;
    logic       low_overflow_irq_enable;
    logic       capture_enable;
    logic       split_select;
    logic       run_control;
    logic       ext_clock_select;
    logic [7:0] count_high_byte;
    logic [7:0] count_low_byte;
  } tmt_state_type;

  typedef struct packed {
    logic [3:0] sys_cnt;
    logic [2:0] ext_cnt;
    logic       ext_prev;
  } tmt_div_state_type;

endpackage : tmt_pkg

// *** hw/tmt_tick_gen.sv ***
`timescale 1ns/1ps
`include "tmt_defines.svh"

// ----------------------------------------------------------------------
// tick generator: system clock / 12 and external clock edges / 8
// ----------------------------------------------------------------------
module tmt_tick_gen
  import tmt_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ext_clk_sync,
  output logic      sys_tick,
  output logic      ext_tick
);

  tmt_div_state_type st_reg;
  tmt_div_state_type st_next;
  logic              ext_rise;

  always_comb begin
    st_next  = st_reg;
    ext_rise = ext_clk_sync & ~st_reg.ext_prev;
    sys_tick = (st_reg.sys_cnt == 4'(`TMT_SYS_DIV - 1));
    ext_tick = ext_rise && (st_reg.ext_cnt == 3'(`TMT_EXT_DIV - 1));
    st_next.ext_prev = ext_clk_sync;
    if (sys_tick) begin
      st_next.sys_cnt = 4'h0;
    end else begin
      st_next.sys_cnt = st_reg.sys_cnt + 4'h1;
    end
    if (ext_rise) begin
      st_next.ext_cnt = st_reg.ext_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : tmt_tick_gen

// *** sim/tmt_timer_chk.sv ***
`timescale 1ns/1ps
// ----------------
// checker
// ----------------
module tmt_timer_chk
  import tmt_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] reload_low,
  input wire logic       timer_irq_enable,
  input wire logic       irq_req,
  input wire logic       capture_mode,
  input wire logic [7:0] count_low
);
  logic       cap_bit;
  logic [3:0] ctl_reg;
  logic       sel;
  assign cap_bit = sfr_wdata[4];
  assign sel = sfr_addr == 8'h91;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctl_reg <= 4'h0;
    else if (sfr_wr && sel) ctl_reg <= sfr_wdata[5:2];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_clear: assert property (disable iff (1'b0) !rst_n |-> !irq_req && !capture_mode)
    else $error("outputs not clear in reset");
  a_unused_zero: assert property (sfr_rdata[1] == 1'b0)
    else $error("unused bit reads one");
  a_other_zero: assert property (!(sfr_rd && sel) |-> sfr_rdata == 8'h00)
    else $error("read data while not selected");
  a_capture_follow: assert property (sfr_wr && sel |=> capture_mode == $past(cap_bit))
    else $error("capture mode not following write");
  a_ctrl_readback: assert property (sfr_rd && sel |-> sfr_rdata[5:2] == ctl_reg)
    else $error("control bits read back wrong");
  a_irq_gate: assert property (irq_req |-> timer_irq_enable)
    else $error("request without timer enable");
  a_flag_sticky: assert property (irq_req && !sfr_wr |=> irq_req || !timer_irq_enable)
    else $error("request dropped without write");
  a_low_reload: assert property ($changed(count_low) && $past(count_low) == 8'hff
    |-> count_low == 8'h00 || count_low == $past(reload_low))
    else $error("low byte wrap wrong");
  a_low_step: assert property ($changed(count_low) && $past(count_low) != 8'hff
    |-> count_low == $past(count_low) + 8'h01)
    else $error("low byte step wrong");
endmodule : tmt_timer_chk

bind tmt_timer tmt_timer_chk tmt_timer_chk_i (.clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr,
  .sfr_rd, .sfr_rdata, .reload_low, .timer_irq_enable, .irq_req, .capture_mode, .count_low);

// *** sim/tmt_timer_tb.sv ***
`timescale 1ns/1ps
// ----------------
// bench
// ----------------
module tmt_timer_tb
  import tmt_pkg::*;
;
  logic       clk, rst_n, sfr_wr, sfr_rd, ext_run, hpick, lpick, tie, irq_req, cap;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rl_h, rl_l, cnt_h, cnt_l, c0, c1;
  logic [1:0] ediv;
  int         error_cnt, samples_checked;
  int         cyc = 0;
  tmt_timer tmt_timer_i (.clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
    .ext_clk(ediv[1]), .high_byte_clock_pick(hpick), .low_byte_clock_pick(lpick),
    .reload_high(rl_h), .reload_low(rl_l), .timer_irq_enable(tie), .irq_req,
    .capture_mode(cap), .count_high(cnt_h), .count_low(cnt_l));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ext_run) ediv <= ediv + 2'h1;
    if (cyc == 8000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    {sfr_rd, sfr_addr} <= {1'b1, a};
    @(negedge clk);
    chk(sfr_rdata & m, e);
    @(posedge clk);
    sfr_rd <= 1'b0;
  endtask : rd
  task automatic gap(input int n);
    @(negedge clk);
    c0 = cnt_l;
    repeat (n) @(negedge clk);
  endtask : gap
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    {rst_n, sfr_wr, sfr_rd, ext_run, hpick, lpick, tie} = '0;
    {sfr_addr, sfr_wdata, rl_h, rl_l, ediv} = '0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h91, 8'hff, 8'h00);
    chk({7'h0, cap}, 8'h00);
    wr(8'h91, 8'h3b);
    rd(8'h91, 8'hff, 8'h39);
    chk({7'h0, cap}, 8'h01);
    wr(8'h91, 8'h00);
    wr(8'h92, 8'h3f);
    rd(8'h91, 8'hff, 8'h00);
    chk({7'h0, cap}, 8'h00);
    wr(8'h91, 8'h04);
    gap(120);
    chk(cnt_l - c0, 8'h0a);
    // start the external clock first so its ticks are periodic over the window
    ext_run <= 1'b1;
    wr(8'h91, 8'h05);
    gap(256);
    chk(cnt_l - c0, 8'h08);
    {rl_h, rl_l, lpick, tie} <= {8'hfe, 8'hf0, 2'b11};
    wr(8'h91, 8'h28);
    @(negedge clk);
    c1 = cnt_h;
    gap(300);
    chk(cnt_h, c1);
    chk(cnt_l & 8'hf0, 8'hf0);
    rd(8'h91, 8'h40, 8'h40);
    chk({7'h0, irq_req}, 8'h01);
    tie <= 1'b0;
    gap(1);
    chk({7'h0, irq_req}, 8'h00);
    tie <= 1'b1;
    wr(8'h91, 8'h08);
    gap(1);
    chk({7'h0, irq_req}, 8'h00);
    hpick <= 1'b1;
    wr(8'h91, 8'h0c);
    gap(300);
    rd(8'h91, 8'h80, 8'h80);
    chk({7'h0, irq_req}, 8'h01);
    chk(cnt_h & 8'hfe, 8'hfe);
    wr(8'h91, 8'h88);
    gap(50);
    rd(8'h91, 8'h80, 8'h80);
    wr(8'h91, 8'h08);
    rd(8'h91, 8'h80, 8'h00);
    rl_h <= 8'hff;
    wr(8'h91, 8'h04);
    gap(600);
    rd(8'h91, 8'h80, 8'h80);
    chk(cnt_h, 8'hff);
    finish_test();
  end
endmodule : tmt_timer_tb
